// >>> verilog/fcpl_responder.sv
// Process login/logout responder: takes request payload bytes and
// streams the accept payload, or pulses a reject.
// Assumes request bytes are synchronous to clk and frame transport is outside.
`timescale 1ns/1ps
module fcpl_responder
   import fcpl_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       ce,
   input  wire logic       req_valid,
   input  wire logic       req_first,
   input  wire logic [7:0] req_data,
   output logic            req_ready,
   output logic            rsp_valid,
   output fcpl_beat_t      rsp_beat,
   input  wire logic       rsp_ready,
   output logic            rjt_valid,
   output fcpl_rjt_t       rjt_info,
   input  wire logic       init_done,
   input  wire logic       resources_ok,
   output logic            img_established,
   output logic            img_reset
);

   fcpl_state_t state_q;
   logic [3:0]  icnt_q;
   logic [3:0]  ocnt_q;
   logic [7:0]  cmd_q;
   logic [7:0]  plen_q;
   logic [7:0]  lenh_q;
   logic [15:0] len_q;
   logic [11:0] pages_q;
   logic        login_q;
   logic        type_ok_q;
   logic [7:0]  flag_hi_q;
   logic        first_pg_q;
   logic [3:0]  code_q;
   logic        opg_q;
   logic        rsp_valid_q;
   fcpl_beat_t  rsp_beat_q;
   logic        rjt_q;
   logic        est_q;
   logic        rst_img_q;

   // One byte of a response page; login and logout differ only in flags
   // and service parameters.
   function automatic logic [7:0] page_byte(input logic [3:0] idx,
                                            input logic [3:0] code,
                                            input logic       login);
      logic [7:0] b;
      b = ZERO_BYTE;
      if (idx == IDX_TYPE) begin
         b = TYPE_FCP;
      end else if (idx == IDX_EXT) begin
         b = TYPE_EXT;
      end else if (idx == IDX_FLAGS) begin
         b = {(login ? FLG_EST_NIB : FLG_NONE), code};
      end else if (idx == IDX_SVC && login) begin
         b = SVC_LOGIN;
      end
      return b;
   endfunction

   function automatic logic [7:0] hdr_byte(input logic [3:0]  idx,
                                           input logic [15:0] len);
      logic [7:0] b;
      case (idx[1:0])
         2'b00: b = ACC_CMD;
         2'b01: b = PAGE_LEN;
         2'b10: b = len[15:8];
         default: b = len[7:0];
      endcase
      return b;
   endfunction

   wire         in_fire   = ce & req_valid & req_ready;
   wire         out_adv   = ce & (~rsp_valid_q | rsp_ready);
   wire [3:0]   hidx      = req_first ? IDX_TYPE : icnt_q;
   wire         hdr_take  = in_fire & (state_q == ST_HDR) & (req_first | icnt_q != IDX_TYPE);
   wire         hdr_end   = hdr_take & (hidx == IDX_HLAST);
   wire [15:0]  len_w     = {lenh_q, req_data};
   wire [15:0]  len_m4    = len_w - LEN_HDR;
   // Lengths that are not a whole number of pages are rejected outright.
   wire         hdr_ok    = (cmd_q == CMD_LOGIN | cmd_q == CMD_LOGOUT) & plen_q == PAGE_LEN
                            & len_w >= LEN_MIN & req_data[3:0] == LEN_ALIGN;
   wire         pg_end    = in_fire & (state_q == ST_PAGE) & (icnt_q == IDX_SVC);
   wire         svc_init  = req_data[SVC_INIT];
   wire         rjt_init  = pg_end & login_q & first_pg_q & ~svc_init;
   wire         out_hdr   = out_adv & (state_q == ST_OHDR);
   wire         out_pg    = out_adv & (state_q == ST_OPAGE);
   wire         pg_out_end = out_pg & (ocnt_q == IDX_SVC);
   wire [3:0]   code_d;

   // Associator checks come right after the type and logout checks because no associator is ever honoured.
   assign code_d = ~type_ok_q                  ? ARC_PREDEF :
                   ~login_q                    ? ARC_EXEC :
                   flag_hi_q[FLG_ORIG]         ? ARC_MULTI :
                   flag_hi_q[FLG_RESP]         ? ARC_NORESP :
                   ~svc_init                   ? ARC_PREDEF :
                   ~init_done                  ? ARC_NOINIT :
                   ~resources_ok               ? ARC_NORES :
                   ARC_EXEC;

   assign req_ready       = ce & (state_q == ST_HDR | state_q == ST_PAGE);
   assign rsp_valid       = rsp_valid_q;
   assign rsp_beat        = rsp_beat_q;
   assign rjt_valid       = rjt_q;
   assign rjt_info.reason = RJT_LOGICAL;
   assign rjt_info.expl   = RJT_NOEXPL;
   assign img_established = est_q;
   assign img_reset       = rst_img_q;

   always_ff @(posedge clk) begin
      if (reset) begin
         state_q <= ST_HDR;
         icnt_q  <= 4'h0;
         ocnt_q  <= 4'h0;
      end else if (ce) begin
         case (state_q)
            ST_HDR: begin
               if (hdr_take) begin
                  icnt_q <= hidx + 4'h1;
               end
               if (hdr_end) begin
                  icnt_q  <= 4'h0;
                  state_q <= hdr_ok ? ST_PAGE : ST_HDR;
               end
            end
            ST_PAGE: begin
               if (in_fire) begin
                  icnt_q <= icnt_q + 4'h1;
               end
               if (pg_end) begin
                  ocnt_q  <= 4'h0;
                  state_q <= rjt_init ? ST_HDR : first_pg_q ? ST_OHDR : ST_OPAGE;
               end
            end
            ST_OHDR: begin
               if (out_hdr) begin
                  ocnt_q <= (ocnt_q == IDX_HLAST) ? 4'h0 : ocnt_q + 4'h1;
                  if (ocnt_q == IDX_HLAST) begin
                     state_q <= ST_OPAGE;
                  end
               end
            end
            ST_OPAGE: begin
               if (out_pg) begin
                  ocnt_q <= ocnt_q + 4'h1;
               end
               if (pg_out_end) begin
                  state_q <= (pages_q == 12'h001) ? ST_HDR : ST_PAGE;
               end
            end
            default: begin
               state_q <= ST_HDR;
            end
         endcase
      end
   end

   // Header and page capture; only the bytes that steer the answer are kept.
   always_ff @(posedge clk) begin
      if (reset) begin
         cmd_q      <= 8'h00;
         plen_q     <= 8'h00;
         lenh_q     <= 8'h00;
         len_q      <= 16'h0000;
         pages_q    <= 12'h000;
         login_q    <= 1'b0;
         type_ok_q  <= 1'b0;
         flag_hi_q  <= 8'h00;
         first_pg_q <= 1'b0;
         code_q     <= 4'h0;
      end else if (ce) begin
         if (hdr_take && hidx == IDX_TYPE) begin
            cmd_q <= req_data;
         end
         if (hdr_take && hidx == IDX_EXT) begin
            plen_q <= req_data;
         end
         if (hdr_take && hidx == IDX_LENH) begin
            lenh_q <= req_data;
         end
         if (hdr_end) begin
            len_q      <= len_w;
            pages_q    <= len_m4[15:4];
            login_q    <= (cmd_q == CMD_LOGIN);
            first_pg_q <= 1'b1;
         end
         if (in_fire && state_q == ST_PAGE) begin
            if (icnt_q == IDX_TYPE) begin
               type_ok_q <= (req_data == TYPE_FCP);
            end else if (icnt_q == IDX_EXT) begin
               type_ok_q <= type_ok_q & (req_data == TYPE_EXT);
            end else if (icnt_q == IDX_FLAGS) begin
               flag_hi_q <= req_data;
            end
         end
         if (pg_end) begin
            code_q <= code_d;
         end
         if (pg_out_end) begin
            pages_q    <= pages_q - 12'h001;
            first_pg_q <= 1'b0;
         end
      end
   end

   // Output byte stream; a byte stands until the consumer takes it.
   always_ff @(posedge clk) begin
      if (reset) begin
         rsp_valid_q <= 1'b0;
         rsp_beat_q  <= '0;
         opg_q       <= 1'b0;
      end else if (out_hdr) begin
         rsp_valid_q      <= 1'b1;
         rsp_beat_q.first <= (ocnt_q == IDX_TYPE);
         rsp_beat_q.last  <= 1'b0;
         rsp_beat_q.data  <= hdr_byte(ocnt_q, len_q);
         opg_q            <= 1'b0;
      end else if (out_pg) begin
         rsp_valid_q      <= 1'b1;
         rsp_beat_q.first <= 1'b0;
         rsp_beat_q.last  <= (ocnt_q == IDX_SVC) & (pages_q == 12'h001);
         rsp_beat_q.data  <= page_byte(ocnt_q, code_q, login_q);
         opg_q            <= 1'b1;
      end else if (out_adv) begin
         rsp_valid_q <= 1'b0;
      end
   end

   // Image pair events: a logout page clears the pair back to reset state.
   always_ff @(posedge clk) begin
      if (reset) begin
         rjt_q     <= 1'b0;
         est_q     <= 1'b0;
         rst_img_q <= 1'b0;
      end else if (ce) begin
         rjt_q     <= rjt_init | (hdr_end & ~hdr_ok);
         est_q     <= pg_end & login_q & ~rjt_init & (code_d == ARC_EXEC);
         rst_img_q <= pg_end & ~login_q;
      end
   end

   logic [3:0] oidx_q;
   always_ff @(posedge clk) begin
      if (reset) begin
         oidx_q <= 4'h0;
      end else if (out_hdr || out_pg) begin
         oidx_q <= ocnt_q;
      end
   end

   chk_page_type: assert property (@(posedge clk) disable iff (reset)
      rsp_valid_q && opg_q && oidx_q == IDX_TYPE |-> rsp_beat_q.data == 8'h08)
      else $error("response page type code wrong");

   chk_acc_hdr: assert property (@(posedge clk) disable iff (reset)
      rsp_valid_q && rsp_beat_q.first |-> !opg_q && rsp_beat_q.data == 8'h02)
      else $error("accept header byte wrong");

   chk_orig_assoc: assert property (@(posedge clk) disable iff (reset)
      ce && pg_end && login_q && type_ok_q && flag_hi_q[7] && !rjt_init |=> code_q == 4'h7)
      else $error("originator associator code not 07h");

   chk_resp_assoc: assert property (@(posedge clk) disable iff (reset)
      pg_end && login_q && type_ok_q && !flag_hi_q[7] && flag_hi_q[6] && !rjt_init
      |=> code_q == 4'h4)
      else $error("responder associator code not 04h");

   chk_login_flags: assert property (@(posedge clk) disable iff (reset)
      rsp_valid_q && opg_q && login_q && oidx_q == IDX_FLAGS
      |-> rsp_beat_q.data == {4'h2, code_q})
      else $error("login flags byte wrong");

   chk_svc_word: assert property (@(posedge clk) disable iff (reset)
      rsp_valid_q && opg_q && oidx_q == IDX_SVC |-> rsp_beat_q.data == (login_q ? 8'h12 : 8'h00))
      else $error("service parameter byte wrong");

   chk_zero_fields: assert property (@(posedge clk) disable iff (reset)
      rsp_valid_q && opg_q && oidx_q > 4'h2 && oidx_q < 4'hF |-> rsp_beat_q.data == 8'h00)
      else $error("associator or reserved byte not zero");

   chk_init_reject: assert property (@(posedge clk) disable iff (reset)
      ce && pg_end && login_q && first_pg_q && !req_data[5] |=> rjt_q ##1 state_q == ST_HDR)
      else $error("missing initiator function not rejected");

   chk_logout_reset: assert property (@(posedge clk) disable iff (reset)
      ce && pg_end && !login_q |=> img_reset && !img_established)
      else $error("logout did not reset image pair");

   chk_page_answer: assert property (@(posedge clk) disable iff (reset)
      ce && pg_end && !rjt_init && rsp_ready |-> ##[1:40] (rsp_valid_q && opg_q && oidx_q == IDX_SVC))
      else $error("page not answered in time");

   cov_login_ok: cover property (@(posedge clk) disable iff (reset) est_q);
   cov_logout: cover property (@(posedge clk) disable iff (reset) rst_img_q);
   cov_reject: cover property (@(posedge clk) disable iff (reset) rjt_q);
   cov_multi: cover property (@(posedge clk) disable iff (reset)
      rsp_valid_q && rsp_beat_q.last && !first_pg_q);

endmodule

// >>> shared/fcpl_pkg.sv
// Constants and types of the process login/logout responder.
// Assumes one clock domain; all lengths are payload byte counts.
// Functional notes
// - Originator associator valid answers code 07h.
// - Responder associator valid answers code 04h.
// - Associator valid flags always returned zero.
// - Login response sets image pair established.
// - Login associator fields returned all zero.
// - Target function one, initiator function zero.
// - Service parameter word returned 00000012h.
// - Codes 01h-05h carry their fixed meanings.
// - Code 06h conditional, 07h single page only.
// - Logout returns image pair to reset state.
// - Logout accept: 02h, 10h, pages echoed.
// - Logout response flags and reserved bytes zero.
// - Login request 20h/10h, accept 02h/10h.
// - Missing initiator function rejects, reason 03h; the code rejects only on the first page of a login.
package fcpl_pkg;
   localparam logic [7:0]  CMD_LOGIN   = 8'h20;
   localparam logic [7:0]  CMD_LOGOUT  = 8'h21;
   localparam logic [7:0]  ACC_CMD     = 8'h02;
   localparam logic [7:0]  PAGE_LEN    = 8'h10;
   localparam logic [7:0]  TYPE_FCP    = 8'h08;
   localparam logic [7:0]  TYPE_EXT    = 8'h00;
   localparam logic [7:0]  SVC_LOGIN   = 8'h12;
   localparam logic [7:0]  ZERO_BYTE   = 8'h00;
   localparam logic [15:0] LEN_HDR     = 16'h0004;
   localparam logic [15:0] LEN_MIN     = 16'h0014;
   localparam logic [3:0]  LEN_ALIGN   = 4'h4;
   localparam int          FLG_ORIG    = 7;
   localparam int          FLG_RESP    = 6;
   localparam logic [3:0]  FLG_EST_NIB = 4'h2;
   localparam logic [3:0]  FLG_NONE    = 4'h0;
   localparam int          SVC_INIT    = 5;
   localparam logic [3:0]  IDX_TYPE    = 4'h0;
   localparam logic [3:0]  IDX_EXT     = 4'h1;
   localparam logic [3:0]  IDX_FLAGS   = 4'h2;
   localparam logic [3:0]  IDX_LENH    = 4'h2;
   localparam logic [3:0]  IDX_HLAST   = 4'h3;
   localparam logic [3:0]  IDX_SVC     = 4'hF;
   localparam logic [3:0]  ARC_EXEC    = 4'h1;
   localparam logic [3:0]  ARC_NORES   = 4'h2;
   localparam logic [3:0]  ARC_NOINIT  = 4'h3;
   localparam logic [3:0]  ARC_NORESP  = 4'h4;
   localparam logic [3:0]  ARC_PREDEF  = 4'h5;
   localparam logic [3:0]  ARC_COND    = 4'h6;
   localparam logic [3:0]  ARC_MULTI   = 4'h7;
   localparam logic [7:0]  RJT_LOGICAL = 8'h03;
   localparam logic [7:0]  RJT_NOEXPL  = 8'h00;

   typedef enum logic [1:0] {
      ST_HDR   = 2'b00,
      ST_PAGE  = 2'b01,
      ST_OHDR  = 2'b10,
      ST_OPAGE = 2'b11
   } fcpl_state_t;

   typedef struct packed {
      logic       first;
      logic       last;
      logic [7:0] data;
   } fcpl_beat_t;

   typedef struct packed {
      logic [7:0] reason;
      logic [7:0] expl;
   } fcpl_rjt_t;
endpackage

// >>> bench/fcpl_init_model.sv
// Initiator model: streams queued request bytes and collects the answer bytes.
// Assumes the bench fills it through send and reads rx_q; it drives on the falling edge.
`timescale 1ns/1ps
module fcpl_init_model
   import fcpl_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       ce,
   input  wire logic       slow,
   input  wire logic       req_ready,
   input  wire logic       rsp_valid,
   input  wire fcpl_beat_t rsp_beat,
   output logic            req_valid,
   output logic            req_first,
   output logic [7:0]      req_data,
   output logic            rsp_ready
);
   logic [8:0] tx_q[$];
   fcpl_beat_t rx_q[$];
   logic       took;

   initial begin
      req_valid = 1'b0;
      req_first = 1'b0;
      req_data = 8'h00;
      rsp_ready = 1'b1;
      took = 1'b0;
   end

   task send(input logic first, input logic [7:0] data);
      tx_q.push_back({first, data});
   endtask

   always @(posedge clk) begin
      took = req_valid & req_ready & ce;
      if (rsp_valid & rsp_ready & ce)
         rx_q.push_back(rsp_beat);
   end

   // A byte is held until the edge that takes it; an idle data line keeps toggling,
   // so a responder that samples it outside a transfer cannot see a stable value.
   always @(negedge clk) begin
      if (took)
         void'(tx_q.pop_front());
      if (tx_q.size() != 0) begin
         req_valid <= 1'b1;
         {req_first, req_data} <= tx_q[0];
      end else begin
         req_valid <= 1'b0;
         req_first <= 1'b0;
         req_data <= ~req_data;
      end
      rsp_ready <= slow ? ~rsp_ready : 1'b1;
   end
endmodule

// >>> bench/fcpl_responder_bench.sv
// Self-checking bench of the process login/logout responder.
// Assumes the responder answers each page before it takes the next one.
`timescale 1ns/1ps
module fcpl_responder_bench
   import fcpl_pkg::*;
;
   logic        clk, reset, ce, init_done, resources_ok, slow;
   logic        req_valid, req_first, req_ready, rsp_valid, rsp_ready, rjt_valid;
   logic        img_established, img_reset;
   logic [7:0]  req_data;
   fcpl_beat_t  rsp_beat;
   fcpl_rjt_t   rjt_info;
   fcpl_beat_t  exp_q[$];
   logic [15:0] rnd_q;
   int          num_errors, samples_checked, est_cnt, rst_cnt, rjt_cnt;

   fcpl_responder fcpl_responder_inst (.clk(clk), .reset(reset), .ce(ce), .req_valid(req_valid),
      .req_first(req_first), .req_data(req_data), .req_ready(req_ready), .rsp_valid(rsp_valid),
      .rsp_beat(rsp_beat), .rsp_ready(rsp_ready), .rjt_valid(rjt_valid), .rjt_info(rjt_info),
      .init_done(init_done), .resources_ok(resources_ok), .img_established(img_established),
      .img_reset(img_reset));

   fcpl_init_model fcpl_init_model_inst (.clk(clk), .ce(ce), .slow(slow), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp_beat(rsp_beat), .req_valid(req_valid), .req_first(req_first),
      .req_data(req_data), .rsp_ready(rsp_ready));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   function logic [15:0] rnd();
      rnd_q = {rnd_q[14:0], rnd_q[15] ^ rnd_q[13] ^ rnd_q[12] ^ rnd_q[10]};
      return rnd_q;
   endfunction

   // A page of the wrong type is refused for logout as well as login.
   function automatic logic [3:0] page_code(logic [15:0] te, logic [7:0] flg, logic b5, logic login);
      if (te !== {TYPE_FCP, TYPE_EXT}) return ARC_PREDEF;
      if (!login) return ARC_EXEC;
      if (flg[7]) return ARC_MULTI;
      if (flg[6]) return ARC_NORESP;
      if (!b5) return ARC_PREDEF;
      if (!init_done) return ARC_NOINIT;
      if (!resources_ok) return ARC_NORES;
      return ARC_EXEC;
   endfunction

   function automatic logic [7:0] exp_byte(int i, logic login, logic [3:0] code);
      case (i)
         0: return TYPE_FCP;
         2: return {login ? FLG_EST_NIB : FLG_NONE, code};
         15: return login ? SVC_LOGIN : ZERO_BYTE;
         default: return ZERO_BYTE;
      endcase
   endfunction

   task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task complete_run();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   always @(posedge clk) begin
      if (!reset) begin
         est_cnt += int'(img_established === 1'b1);
         rst_cnt += int'(img_reset === 1'b1);
         rjt_cnt += int'(rjt_valid === 1'b1);
         if (rjt_valid === 1'b1) check("reject info", rjt_info, {RJT_LOGICAL, RJT_NOEXPL});
      end
   end

   task automatic run(input logic [7:0] cmd, input logic [7:0] plen, input logic [15:0] len,
                      input int pages, input logic b5_off);
      logic [7:0]  pg[16];
      logic [15:0] r;
      logic [3:0]  code;
      logic        login, bad;
      int          n, e0, r0, j0, est;
      login = (cmd == CMD_LOGIN);
      bad = !(login || cmd == CMD_LOGOUT) || plen != PAGE_LEN || len < LEN_MIN
            || len[3:0] != LEN_ALIGN || (login && b5_off);
      e0 = est_cnt;
      r0 = rst_cnt;
      j0 = rjt_cnt;
      est = 0;
      exp_q.delete();
      fcpl_init_model_inst.rx_q.delete();
      @(posedge clk);
      fcpl_init_model_inst.send(1'b1, cmd);
      fcpl_init_model_inst.send(1'b0, plen);
      fcpl_init_model_inst.send(1'b0, len[15:8]);
      fcpl_init_model_inst.send(1'b0, len[7:0]);
      if (!bad) begin
         exp_q.push_back({2'b10, ACC_CMD});
         exp_q.push_back({2'b00, PAGE_LEN});
         exp_q.push_back({2'b00, len[15:8]});
         exp_q.push_back({2'b00, len[7:0]});
      end
      for (int p = 0; p < pages; p++) begin
         r = rnd();
         foreach (pg[i]) pg[i] = 8'h00;
         {pg[0], pg[1]} = (r[12:10] == 3'h0) ? rnd() : {TYPE_FCP, TYPE_EXT};
         pg[2] = {r[1:0] == 2'h0, r[3:2] == 2'h0, 6'h00};
         if (login) pg[15] = {2'h0, p == 0 ? !b5_off : r[6:4] != 3'h0, 5'h00};
         foreach (pg[i]) fcpl_init_model_inst.send(1'b0, pg[i]);
         code = page_code({pg[0], pg[1]}, pg[2], pg[15][5], login);
         est += int'(!bad && login && code == ARC_EXEC);
         for (int i = 0; i < 16 && !bad; i++)
            exp_q.push_back({1'b0, i == 15 && p == pages - 1, exp_byte(i, login, code)});
      end
      for (n = 0; n < 3000; n++) begin
         @(negedge clk);
         if (fcpl_init_model_inst.tx_q.size() == 0 &&
             (bad ? rjt_cnt > j0 : fcpl_init_model_inst.rx_q.size() >= exp_q.size())) break;
      end
      if (n == 3000) begin
         num_errors++;
         $display("CHECK FAILED answer wait expected done seen timeout");
         complete_run();
      end
      repeat (4) @(negedge clk);
      check("answer length", 16'(fcpl_init_model_inst.rx_q.size()), 16'(exp_q.size()));
      foreach (exp_q[i]) check("answer byte", 16'(fcpl_init_model_inst.rx_q[i]), 16'(exp_q[i]));
      check("established pulses", 16'(est_cnt - e0), 16'(est));
      check("image reset pulses", 16'(rst_cnt - r0), 16'((bad || login) ? 0 : pages));
      check("reject pulses", 16'(rjt_cnt - j0), 16'(bad));
   endtask

   initial begin
      logic [15:0] r;
      int          k;
      reset = 1'b1;
      ce = 1'b1;
      init_done = 1'b1;
      resources_ok = 1'b1;
      slow = 1'b0;
      rnd_q = 16'hE73E;
      num_errors = 0;
      samples_checked = 0;
      est_cnt = 0;
      rst_cnt = 0;
      rjt_cnt = 0;
      repeat (10) @(negedge clk);
      reset = 1'b0;
      run(CMD_LOGIN, PAGE_LEN, 16'h0014, 1, 1'b0);
      run(CMD_LOGIN, PAGE_LEN, 16'h0014, 1, 1'b1);
      run(8'h22, PAGE_LEN, 16'h0014, 1, 1'b0);
      run(CMD_LOGOUT, 8'h11, 16'h0014, 1, 1'b0);
      run(CMD_LOGIN, PAGE_LEN, 16'h0010, 1, 1'b0);
      run(CMD_LOGOUT, PAGE_LEN, 16'h0015, 1, 1'b0);
      init_done = 1'b0;
      run(CMD_LOGIN, PAGE_LEN, 16'h0024, 2, 1'b0);
      init_done = 1'b1;
      resources_ok = 1'b0;
      run(CMD_LOGIN, PAGE_LEN, 16'h0014, 1, 1'b0);
      resources_ok = 1'b1;
      ce = 1'b0;
      repeat (3) @(negedge clk);
      ce = 1'b1;
      for (k = 0; k < 40; k++) begin
         r = rnd();
         slow = r[0];
         init_done = r[3:1] != 3'h0;
         resources_ok = r[6:4] != 3'h0;
         run(r[10] ? CMD_LOGOUT : CMD_LOGIN, PAGE_LEN, 16'(20 + 16 * r[9:8]), 1 + r[9:8], 1'b0);
      end
      complete_run();
   end
endmodule
